// *** nsr_pkg.sv ***
`default_nettype none
package nsr_pkg;
  // i/o port map
  localparam logic [7:0] PORT_ICTL1_BASE = 8'h20;
  localparam logic [7:0] PORT_ICTL1_INIT = 8'h21;
  localparam logic [7:0] PORT_NMI_STS = 8'h61;
  localparam logic [7:0] PORT_NMI_MASK = 8'h70;
  localparam logic [7:0] PORT_ICTL2_BASE = 8'ha0;
  localparam logic [7:0] PORT_ICTL2_INIT = 8'ha1;
  localparam logic [7:0] IO_UNMAPPED_DATA = 8'hff;
  // configuration space offsets
  localparam logic [7:0] CFG_ROUTE_FIRST = 8'h60;
  localparam logic [7:0] CFG_ROUTE_LAST = 8'h63;
  localparam logic [7:0] CFG_ADVANCED_IRQ_MODE_TOP = 8'h64;
  // nmi status/control port fields
  localparam int NS_PAR_STS = 7;
  localparam int NS_CHK_STS = 6;
  localparam int NS_SPK_OUT = 5;
  localparam int NS_REFRESH = 4;
  localparam int NS_CHK_DIS = 3;
  localparam int NS_PAR_DIS = 2;
  localparam int NS_SPK_DATA = 1;
  localparam int NS_T2_GATE = 0;
  localparam int NMI_MASK_BIT = 7;
  // init command word fields
  localparam int ICW1_FLAG_BIT = 4;
  localparam int ICW1_SINGLE_BIT = 1;
  localparam int ICW1_ICW4_BIT = 0;
  // reset values
  localparam logic [7:0] NMI_CTL_RESET = 8'h0c;
  localparam logic NMI_MASK_RESET = 1'b1;
  localparam logic [7:0] ICTL_MASK_RESET = 8'hff;
  // sizes
  localparam int ISA_IRQS = 16;
  localparam int PIRQ_LINES = 8;
  localparam int ADVANCED_IRQ_MODE_INPUTS = 24;
  localparam int SLOTS = 5;
  localparam int CASCADE_IRQ = 2;
  // slot pin rotation: slot1, slot2, expansion connector, slot3, slot4
  localparam logic [1:0] SLOT_ROT [SLOTS] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h0};
  // legacy service order, highest first (irq2 is the cascade)
  localparam logic [3:0] LEG_ORDER [15] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'ha, 4'hb,
    4'hc, 4'hd, 4'he, 4'hf, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
  typedef enum {ICW_READY, ICW_WAIT2, ICW_WAIT3, ICW_WAIT4} nsr_icw_t;
endpackage : nsr_pkg
`default_nettype wire

// *** nsr_irq_glue.sv ***
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - advanced mode takes 24 inputs, rotating programmable priority, no acknowledge.
// - eight active-low pci interrupt lines a to h are provided.
// - slots 1,4 drive e-h straight; slot 2/expansion rotate d,a,b,c; slot 3 c,d,a,b.
// - config bytes 60h-63h map each pci line onto one isa request.
// - legacy controllers at 020h/021h and 0a0h/0a1h; upper port takes icw2-4.
// - smi outranks nmi, nmi outranks the legacy intr; advanced mode messages are sent regardless of smi or nmi.
// - nmi raised by pci parity/system error or processor internal error.
// - status bit 7 read-only, set by pci parity or system error.
// - status bit 6 read-only, high while channel check low and enabled.
// - bit 3 set disables channel-check nmi and clears its status.
// - bit 2 set disables parity nmi and clears its status.
// - bit 5 reads timer counter 2 output.
// - bit 4 toggles on every memory refresh cycle.
// - bit 1 speaker data, bit 0 counter 2 gate, both read/write.
// - pulsing bit 2 or 3 clears status 7 or 6 after service.
// - bit 7 at port 070h masks nmi generation.
// - with power management on, expired inactivity timer asserts smi.
// - legacy mode serves highest priority pending request first.
module nsr_irq_glue #(
  parameter int N_TIMERS = 4,
  parameter int TIMER_W = 16,
  parameter logic [15:0] INACT_LIMIT = 16'h03e8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rdata_valid,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic [nsr_pkg::SLOTS*4-1:0] slot_int_n,
  input wire logic [3:0] onboard_pirq_n,
  output logic [nsr_pkg::PIRQ_LINES-1:0] pci_irq_lines_a_to_h_n,
  input wire logic [nsr_pkg::ISA_IRQS-1:0] isa_irq,
  input wire logic advanced_irq_mode,
  output logic [nsr_pkg::ISA_IRQS-1:0] legacy_irq_request,
  output logic intr_out,
  input wire logic inta,
  output logic [7:0] inta_vector,
  output logic advanced_irq_mode_msg_valid,
  output logic [4:0] advanced_irq_mode_msg_irq,
  input wire logic perr_n,
  input wire logic serr_n,
  input wire logic channel_check_n,
  input wire logic cpu_internal_error_a,
  input wire logic cpu_internal_error_b,
  output logic nmi_out,
  input wire logic timer2_out,
  input wire logic refresh_pulse,
  output logic speaker_data,
  output logic timer2_gate,
  output logic [6:0] rtc_index,
  input wire logic pm_enable,
  input wire logic [N_TIMERS-1:0] activity,
  input wire logic smi_ack,
  output logic system_mgmt_irq_n
);
  import nsr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pci line gathering and slot rotation

  logic [PIRQ_LINES-1:0] pirq_act;
  logic [7:0] route_reg [4];
  logic [ISA_IRQS-1:0] routed;

  // e-h are shared by all slots, each with its own pin rotation
  always_comb begin
    pirq_act = {4'h0, ~onboard_pirq_n};
    for (int s = 0; s < SLOTS; s++) begin
      for (int k = 0; k < 4; k++) begin
        pirq_act[4+k] = pirq_act[4+k] | ~slot_int_n[s*4 + int'(2'(k - SLOT_ROT[s]))];
      end
    end
  end

  // line i uses low nibble of route byte i, line i+4 the high nibble
  always_comb begin
    routed = '0;
    for (int i = 0; i < 4; i++) begin
      if (route_reg[i][3:0] != 4'h0) routed[route_reg[i][3:0]] |= pirq_act[i];
      if (route_reg[i][7:4] != 4'h0) routed[route_reg[i][7:4]] |= pirq_act[i+4];
    end
  end

  // registered line and request outputs
  always_ff @(posedge mclk) begin
    if (srst) begin
      pci_irq_lines_a_to_h_n <= '1;
      legacy_irq_request <= '0;
    end else if (ce) begin
      pci_irq_lines_a_to_h_n <= ~pirq_act;
      legacy_irq_request <= isa_irq | routed;
    end
  end

  // configuration bytes: routing and advanced priority top
  logic [4:0] advanced_irq_mode_top_reg;
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < 4; i++) route_reg[i] <= 8'h00;
      advanced_irq_mode_top_reg <= 5'h00;
      cfg_rdata <= 8'h00;
    end else if (ce) begin
      if (cfg_wr && cfg_addr >= CFG_ROUTE_FIRST && cfg_addr <= CFG_ROUTE_LAST)
        route_reg[cfg_addr[1:0]] <= cfg_wdata;
      if (cfg_wr && cfg_addr == CFG_ADVANCED_IRQ_MODE_TOP && cfg_wdata[4:0] < 5'(ADVANCED_IRQ_MODE_INPUTS))
        advanced_irq_mode_top_reg <= cfg_wdata[4:0];
      if (cfg_rd) begin
        if (cfg_addr >= CFG_ROUTE_FIRST && cfg_addr <= CFG_ROUTE_LAST)
          cfg_rdata <= route_reg[cfg_addr[1:0]];
        else if (cfg_addr == CFG_ADVANCED_IRQ_MODE_TOP) cfg_rdata <= {3'h0, advanced_irq_mode_top_reg};
        else cfg_rdata <= IO_UNMAPPED_DATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // legacy controller pair: init sequence, masks, vector bases

  nsr_icw_t icw_state [2];
  logic [7:0] imask_reg [2];
  logic [4:0] vbase_reg [2];
  logic icw4_reg [2];
  logic single_reg [2];
  logic [7:0] irr [2];

  generate
    for (genvar c = 0; c < 2; c++) begin : g_ictl
      logic base_hit;
      logic init_hit;
      assign base_hit = io_wr && io_addr == (c == 0 ? PORT_ICTL1_BASE : PORT_ICTL2_BASE);
      assign init_hit = io_wr && io_addr == (c == 0 ? PORT_ICTL1_INIT : PORT_ICTL2_INIT);
      assign irr[c] = legacy_irq_request[c*8 +: 8];
      // icw1 at base port restarts; icw2-4 then mask at upper port
      always_ff @(posedge mclk) begin
        if (srst) begin
          icw_state[c] <= ICW_READY;
          imask_reg[c] <= ICTL_MASK_RESET;
          vbase_reg[c] <= 5'h00;
          icw4_reg[c] <= 1'b0;
          single_reg[c] <= 1'b0;
        end else if (ce) begin
          if (base_hit && io_wdata[ICW1_FLAG_BIT]) begin
            icw_state[c] <= ICW_WAIT2;
            icw4_reg[c] <= io_wdata[ICW1_ICW4_BIT];
            single_reg[c] <= io_wdata[ICW1_SINGLE_BIT];
            imask_reg[c] <= 8'h00;
          end else if (init_hit) begin
            case (icw_state[c])
              ICW_WAIT2: begin
                vbase_reg[c] <= io_wdata[7:3];
                if (!single_reg[c]) icw_state[c] <= ICW_WAIT3;
                else if (icw4_reg[c]) icw_state[c] <= ICW_WAIT4;
                else icw_state[c] <= ICW_READY;
              end
              ICW_WAIT3: icw_state[c] <= icw4_reg[c] ? ICW_WAIT4 : ICW_READY;
              ICW_WAIT4: icw_state[c] <= ICW_READY;
              ICW_READY: imask_reg[c] <= io_wdata;
              default: icw_state[c] <= ICW_READY;
            endcase
          end
        end
      end
    end
  endgenerate

  // fixed legacy priority search; second controller enters via cascade
  logic [15:0] leg_pend;
  logic leg_any;
  logic [3:0] leg_win;
  always_comb begin
    leg_pend = {irr[1] & ~imask_reg[1], irr[0] & ~imask_reg[0]};
    leg_pend[CASCADE_IRQ] = 1'b0;
    if (imask_reg[0][CASCADE_IRQ]) leg_pend[15:8] = 8'h00;
    leg_any = 1'b0;
    leg_win = 4'h0;
    for (int p = 14; p >= 0; p--) begin
      if (leg_pend[LEG_ORDER[p]]) begin
        leg_any = 1'b1;
        leg_win = LEG_ORDER[p];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // advanced mode: 24 inputs, rotating priority, message delivery

  logic [ADVANCED_IRQ_MODE_INPUTS-1:0] advanced_irq_mode_src;
  logic [ADVANCED_IRQ_MODE_INPUTS-1:0] advanced_irq_mode_sent_reg;
  logic advanced_irq_mode_any;
  logic [4:0] advanced_irq_mode_win;
  always_comb begin
    int idx;
    idx = 0;
    advanced_irq_mode_src = {pirq_act, legacy_irq_request};
    advanced_irq_mode_any = 1'b0;
    advanced_irq_mode_win = 5'h00;
    for (int k = ADVANCED_IRQ_MODE_INPUTS - 1; k >= 0; k--) begin
      idx = int'(advanced_irq_mode_top_reg) + k;
      if (idx >= ADVANCED_IRQ_MODE_INPUTS) idx = idx - ADVANCED_IRQ_MODE_INPUTS;
      if (advanced_irq_mode_src[idx] && !advanced_irq_mode_sent_reg[idx]) begin
        advanced_irq_mode_any = 1'b1;
        advanced_irq_mode_win = 5'(idx);
      end
    end
  end

  // one message per rising request, no acknowledge cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      advanced_irq_mode_sent_reg <= '0;
      advanced_irq_mode_msg_valid <= 1'b0;
      advanced_irq_mode_msg_irq <= 5'h00;
    end else if (ce) begin
      advanced_irq_mode_sent_reg <= advanced_irq_mode_sent_reg & advanced_irq_mode_src;
      advanced_irq_mode_msg_valid <= 1'b0;
      if (advanced_irq_mode && advanced_irq_mode_any) begin
        advanced_irq_mode_sent_reg[advanced_irq_mode_win] <= 1'b1;
        advanced_irq_mode_msg_valid <= 1'b1;
        advanced_irq_mode_msg_irq <= advanced_irq_mode_win;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // nmi status/control, global mask, refresh indicator

  logic par_sts_reg;
  logic chk_sts_reg;
  logic ierr_sts_reg;
  logic chk_dis_reg;
  logic par_dis_reg;
  logic refresh_reg;
  logic nmi_mask_reg;
  logic sts_wr;
  assign sts_wr = io_wr && io_addr == PORT_NMI_STS;

  // control bits written at the status port
  always_ff @(posedge mclk) begin
    if (srst) begin
      chk_dis_reg <= NMI_CTL_RESET[NS_CHK_DIS];
      par_dis_reg <= NMI_CTL_RESET[NS_PAR_DIS];
      speaker_data <= NMI_CTL_RESET[NS_SPK_DATA];
      timer2_gate <= NMI_CTL_RESET[NS_T2_GATE];
    end else if (ce && sts_wr) begin
      chk_dis_reg <= io_wdata[NS_CHK_DIS];
      par_dis_reg <= io_wdata[NS_PAR_DIS];
      speaker_data <= io_wdata[NS_SPK_DATA];
      timer2_gate <= io_wdata[NS_T2_GATE];
    end
  end

  // source status; a disable bit written high clears at once, unless a parity or internal error in that same cycle sets its status
  always_ff @(posedge mclk) begin
    if (srst) begin
      par_sts_reg <= 1'b0;
      chk_sts_reg <= 1'b0;
      ierr_sts_reg <= 1'b0;
    end else if (ce) begin
      if (!par_dis_reg && (!perr_n || !serr_n)) par_sts_reg <= 1'b1;
      else if (par_dis_reg || (sts_wr && io_wdata[NS_PAR_DIS])) par_sts_reg <= 1'b0;
      chk_sts_reg <= !channel_check_n && !chk_dis_reg && !(sts_wr && io_wdata[NS_CHK_DIS]);
      if (cpu_internal_error_a || cpu_internal_error_b) ierr_sts_reg <= 1'b1;
      else if (sts_wr && io_wdata[NS_PAR_DIS]) ierr_sts_reg <= 1'b0;
    end
  end

  // refresh indicator and global mask with clock index pass-through
  always_ff @(posedge mclk) begin
    if (srst) begin
      refresh_reg <= 1'b0;
      nmi_mask_reg <= NMI_MASK_RESET;
      rtc_index <= 7'h00;
    end else if (ce) begin
      if (refresh_pulse) refresh_reg <= ~refresh_reg;
      if (io_wr && io_addr == PORT_NMI_MASK) begin
        nmi_mask_reg <= io_wdata[NMI_MASK_BIT];
        rtc_index <= io_wdata[6:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // inactivity timers and smi

  logic [N_TIMERS-1:0] expired;
  logic smi_pend_reg;
  generate
    for (genvar t = 0; t < N_TIMERS; t++) begin : g_tmr
      logic [TIMER_W-1:0] cnt_reg;
      assign expired[t] = cnt_reg == TIMER_W'(INACT_LIMIT);
      // counts idle cycles, restarts on activity
      always_ff @(posedge mclk) begin
        if (srst) cnt_reg <= '0;
        else if (ce) begin
          if (activity[t] || !pm_enable) cnt_reg <= '0;
          else if (!expired[t]) cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  endgenerate

  // set wins over the acknowledge
  always_ff @(posedge mclk) begin
    if (srst) smi_pend_reg <= 1'b0;
    else if (ce) begin
      if (pm_enable && |expired) smi_pend_reg <= 1'b1;
      else if (smi_ack) smi_pend_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // processor-facing outputs with smi > nmi > maskable ranking

  logic nmi_cond;
  assign nmi_cond = !nmi_mask_reg && ((par_sts_reg && !par_dis_reg) ||
    (chk_sts_reg && !chk_dis_reg) || ierr_sts_reg);
  always_ff @(posedge mclk) begin
    if (srst) begin
      system_mgmt_irq_n <= 1'b1;
      nmi_out <= 1'b0;
      intr_out <= 1'b0;
      inta_vector <= 8'h00;
    end else if (ce) begin
      system_mgmt_irq_n <= !smi_pend_reg;
      nmi_out <= nmi_cond && !smi_pend_reg;
      intr_out <= !advanced_irq_mode && leg_any && !nmi_cond && !smi_pend_reg;
      if (inta && leg_any)
        inta_vector <= {vbase_reg[leg_win[3]], leg_win[2:0]};
    end
  end

  // port reads
  always_ff @(posedge mclk) begin
    if (srst) begin
      io_rdata <= 8'h00;
      io_rdata_valid <= 1'b0;
    end else if (ce) begin
      io_rdata_valid <= io_rd;
      if (io_rd) begin
        case (io_addr)
          PORT_ICTL1_BASE: io_rdata <= irr[0];
          PORT_ICTL1_INIT: io_rdata <= imask_reg[0];
          PORT_ICTL2_BASE: io_rdata <= irr[1];
          PORT_ICTL2_INIT: io_rdata <= imask_reg[1];
          PORT_NMI_STS: io_rdata <= {par_sts_reg, chk_sts_reg, timer2_out, refresh_reg,
            chk_dis_reg, par_dis_reg, speaker_data, timer2_gate};
          default: io_rdata <= IO_UNMAPPED_DATA;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_mask_blocks_nmi: assert property (@(posedge mclk) disable iff (srst)
    (ce && nmi_mask_reg) |=> !nmi_out) else $error("nmi passed the global mask");
  chk_smi_over_nmi: assert property (@(posedge mclk) disable iff (srst)
    !system_mgmt_irq_n |-> !nmi_out && !intr_out) else $error("nmi or intr beside smi");
  chk_nmi_over_intr: assert property (@(posedge mclk) disable iff (srst)
    nmi_out |-> !intr_out) else $error("intr beside nmi");
  chk_par_clear: assert property (@(posedge mclk) disable iff (srst)
    (ce && sts_wr && io_wdata[NS_PAR_DIS]) |=> ##1 (!ce || !par_sts_reg))
    else $error("parity status not cleared");
  chk_chk_follow: assert property (@(posedge mclk) disable iff (srst)
    (ce && !channel_check_n && !chk_dis_reg && !sts_wr) |=> chk_sts_reg)
    else $error("channel check status missed");
  chk_slot2_rotate: assert property (@(posedge mclk) disable iff (srst)
    (ce && !slot_int_n[4]) |=> !pci_irq_lines_a_to_h_n[5]) else $error("slot 2 pin a not on f");
  chk_refresh_toggle: assert property (@(posedge mclk) disable iff (srst)
    (ce && refresh_pulse) |=> refresh_reg != $past(refresh_reg)) else $error("refresh bit stuck");
  chk_ierr_raises_nmi: assert property (@(posedge mclk) disable iff (srst)
    (ce && ierr_sts_reg && !nmi_mask_reg && !smi_pend_reg) |=> nmi_out)
    else $error("internal error gave no nmi");
  chk_smi_on_expiry: assert property (@(posedge mclk) disable iff (srst)
    (ce && pm_enable && |expired) |=> ##1 (!ce || !system_mgmt_irq_n))
    else $error("expired timer gave no smi");
  chk_advanced_irq_mode_no_intr: assert property (@(posedge mclk) disable iff (srst)
    (ce && advanced_irq_mode) |=> !intr_out) else $error("intr in advanced mode");
endmodule : nsr_irq_glue
`default_nettype wire

// *** nsr_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module nsr_host_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic intr_out,
  input wire logic system_mgmt_irq_n,
  input wire logic inta_req,
  output logic inta = 1'b0,
  output logic smi_ack = 1'b0
);
  logic want_reg = 1'b0;
  logic [2:0] smi_cnt_reg = 3'h0;
  ////////////////////////////////////////////////////////////////
  // one acknowledge per request, only while intr is up
  always @(negedge mclk) begin
    inta <= 1'b0;
    if (srst) begin
      want_reg <= 1'b0;
    end else if (inta_req) begin
      want_reg <= 1'b1;
    end else if (want_reg && intr_out) begin
      inta <= 1'b1;
      want_reg <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////
  // slow management handler, acks a few cycles late
  always @(negedge mclk) begin
    smi_ack <= 1'b0;
    if (srst || system_mgmt_irq_n) begin
      smi_cnt_reg <= 3'h0;
    end else if (smi_cnt_reg == 3'h4) begin
      smi_ack <= 1'b1;
      smi_cnt_reg <= 3'h0;
    end else begin
      smi_cnt_reg <= smi_cnt_reg + 3'h1;
    end
  end
endmodule : nsr_host_model
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import nsr_pkg::*;
  logic mclk, srst, io_wr, io_rd, cfg_wr, cfg_rd, adv, inta, smi_ack, inta_req;
  logic perr_n, serr_n, chk_n, ierr_a, ierr_b, t2_out, refresh, pm_en, rd_valid;
  logic nmi, intr, smi_n, spk, gate, msg_valid, ce;
  logic [7:0] io_addr, io_wdata, io_rdata, cfg_addr, cfg_wdata, cfg_rdata, pci_n, vector;
  logic [19:0] slot_n;
  logic [3:0] onb_n, activity;
  logic [15:0] isa, leg;
  logic [6:0] rtc;
  logic [4:0] msg_irq;
  int failures = 0;
  int compares = 0;
  localparam logic [1:0] ROT [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h0};
  localparam logic [15:0] INIT_SEQ [10] = '{16'h2011, 16'h2108, 16'h2104, 16'h2101,
    16'h2100, 16'ha011, 16'ha170, 16'ha102, 16'ha101, 16'ha100};
  ////////////////////////////////////////////////////////////////
  // device and host
  nsr_irq_glue #(.INACT_LIMIT(16'h0005)) u_dut (.mclk(mclk), .srst(srst), .ce(ce),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rdata_valid(rd_valid), .cfg_addr(cfg_addr),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .slot_int_n(slot_n), .onboard_pirq_n(onb_n), .pci_irq_lines_a_to_h_n(pci_n),
    .isa_irq(isa), .advanced_irq_mode(adv), .legacy_irq_request(leg),
    .intr_out(intr), .inta(inta), .inta_vector(vector), .advanced_irq_mode_msg_valid(msg_valid),
    .advanced_irq_mode_msg_irq(msg_irq), .perr_n(perr_n), .serr_n(serr_n),
    .channel_check_n(chk_n), .cpu_internal_error_a(ierr_a),
    .cpu_internal_error_b(ierr_b), .nmi_out(nmi), .timer2_out(t2_out),
    .refresh_pulse(refresh), .speaker_data(spk), .timer2_gate(gate),
    .rtc_index(rtc), .pm_enable(pm_en), .activity(activity), .smi_ack(smi_ack),
    .system_mgmt_irq_n(smi_n));
  nsr_host_model u_host (.mclk(mclk), .srst(srst), .intr_out(intr),
    .system_mgmt_irq_n(smi_n), .inta_req(inta_req), .inta(inta), .smi_ack(smi_ack));
  ////////////////////////////////////////////////////////////////
  // shared helpers, all entered and left on a falling edge
  task finish_test;
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task iow(input logic [7:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    cyc(1);
    io_wr = 1'b0;
    cyc(1);
  endtask : iow
  task ior(input logic [7:0] a, input logic [7:0] exp);
    io_addr = a;
    io_rd = 1'b1;
    cyc(1);
    io_rd = 1'b0;
    // valid stands for one cycle only, so look before the next edge
    chk(rd_valid, 1'b1);
    chk(io_rdata, exp);
    cyc(1);
  endtask : ior
  task cfgw(input logic [7:0] a, input logic [7:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    cyc(1);
    cfg_wr = 1'b0;
    cyc(1);
  endtask : cfgw
  task cfgr(input logic [7:0] a, input logic [7:0] exp);
    cfg_addr = a;
    cfg_rd = 1'b1;
    cyc(1);
    cfg_rd = 1'b0;
    cyc(1);
    chk(cfg_rdata, exp);
  endtask : cfgr
  task wmsg(input logic [4:0] exp);
    logic seen;
    seen = 1'b0;
    repeat (6) begin
      cyc(1);
      if (msg_valid === 1'b1 && !seen) begin
        seen = 1'b1;
        chk(msg_irq, exp);
      end
    end
    chk(seen, 1'b1);
  endtask : wmsg
  // one-cycle pulse of the error inputs {perr, serr, ierr_a, ierr_b}
  task err_pulse(input logic [3:0] src);
    perr_n = ~src[3];
    serr_n = ~src[2];
    ierr_a = src[1];
    ierr_b = src[0];
    cyc(1);
    {perr_n, serr_n, ierr_a, ierr_b} = 4'hc;
    cyc(2);
  endtask : err_pulse
  ////////////////////////////////////////////////////////////////
  // scenarios
  task t_reset;
    ior(PORT_NMI_STS, 8'h0c);
    ior(PORT_NMI_MASK, 8'hff);
    ior(8'h55, 8'hff);
    ior(PORT_ICTL1_INIT, 8'hff);
    chk(pci_n, 8'hff);
  endtask : t_reset
  task t_status;
    t2_out = 1'b1;
    refresh = 1'b1;
    cyc(1);
    refresh = 1'b0;
    iow(PORT_NMI_STS, 8'hf3);
    ior(PORT_NMI_STS, 8'h33);
    chk({spk, gate}, 2'b11);
    refresh = 1'b1;
    cyc(1);
    refresh = 1'b0;
    t2_out = 1'b0;
    iow(PORT_NMI_STS, 8'h0c);
    ior(PORT_NMI_STS, 8'h0c);
    chk({spk, gate}, 2'b00);
  endtask : t_status
  // clock enable low: refresh pulse and port write must leave no trace
  task t_freeze;
    ce = 1'b0;
    refresh = 1'b1;
    cyc(1);
    refresh = 1'b0;
    iow(PORT_NMI_STS, 8'h03);
    ce = 1'b1;
    ior(PORT_NMI_STS, 8'h0c);
    chk({spk, gate}, 2'b00);
  endtask : t_freeze
  task t_nmi;
    iow(PORT_NMI_MASK, 8'h0d);
    chk(rtc, 7'h0d);
    for (int i = 0; i < 4; i++) begin
      iow(PORT_NMI_STS, 8'h00);
      err_pulse(4'h8 >> i);
      chk(nmi, 1'b1);
      ior(PORT_NMI_STS, (i < 2) ? 8'h80 : 8'h00);
      iow(PORT_NMI_STS, 8'h04);
      ior(PORT_NMI_STS, 8'h04);
      chk(nmi, 1'b0);
    end
    err_pulse(4'h8);
    ior(PORT_NMI_STS, 8'h04);
    iow(PORT_NMI_STS, 8'h00);
    iow(PORT_NMI_MASK, 8'h8d);
    err_pulse(4'h4);
    chk(nmi, 1'b0);
    ior(PORT_NMI_STS, 8'h80);
    iow(PORT_NMI_MASK, 8'h0d);
    cyc(3);
    chk(nmi, 1'b1);
    iow(PORT_NMI_STS, 8'h04);
  endtask : t_nmi
  task t_chk;
    iow(PORT_NMI_STS, 8'h00);
    chk_n = 1'b0;
    cyc(3);
    chk(nmi, 1'b1);
    ior(PORT_NMI_STS, 8'h40);
    chk_n = 1'b1;
    cyc(3);
    ior(PORT_NMI_STS, 8'h00);
    chk_n = 1'b0;
    cyc(3);
    iow(PORT_NMI_STS, 8'h08);
    ior(PORT_NMI_STS, 8'h08);
    chk(nmi, 1'b0);
    chk_n = 1'b1;
    iow(PORT_NMI_STS, 8'h04);
  endtask : t_chk
  task t_route;
    for (int s = 0; s < 5; s++) begin
      for (int p = 0; p < 4; p++) begin
        slot_n = ~(20'h1 << (s * 4 + p));
        cyc(2);
        chk(pci_n, 8'(~(8'h10 << ((p + ROT[s]) % 4))));
      end
    end
    slot_n = 20'hfffff;
    for (int p = 0; p < 4; p++) begin
      onb_n = ~(4'h1 << p);
      cyc(2);
      chk(pci_n, 8'(~(8'h01 << p)));
    end
    cfgw(CFG_ROUTE_FIRST, 8'hb5);
    cfgw(CFG_ROUTE_LAST, 8'h3c);
    cfgr(CFG_ROUTE_FIRST, 8'hb5);
    cfgr(8'h70, 8'hff);
    onb_n = 4'he;
    slot_n = ~20'h1;
    cyc(3);
    chk(leg, 16'h0820);
    onb_n = 4'h7;
    slot_n = ~20'h8;
    cyc(3);
    chk(leg, 16'h1008);
    onb_n = 4'hf;
    slot_n = 20'hfffff;
  endtask : t_route
  task t_legacy;
    for (int i = 0; i < 10; i++) iow(INIT_SEQ[i][15:8], INIT_SEQ[i][7:0]);
    ior(PORT_ICTL2_INIT, 8'h00);
    isa = 16'h0188;
    cyc(3);
    chk(intr, 1'b1);
    inta_req <= 1'b1;
    cyc(1);
    inta_req <= 1'b0;
    cyc(4);
    chk(vector, 8'h70);
    iow(PORT_NMI_STS, 8'h00);
    err_pulse(4'h8);
    chk(intr, 1'b0);
    chk(nmi, 1'b1);
    iow(PORT_NMI_STS, 8'h04);
    isa = 16'h0000;
  endtask : t_legacy
  task t_advanced_irq_mode;
    adv = 1'b1;
    cyc(2);
    isa = 16'h0010;
    wmsg(5'd4);
    isa = 16'h0000;
    onb_n = 4'hd;
    wmsg(5'd17);
    onb_n = 4'hf;
    // priority top at 5: of inputs 4 and 6 raised together, 6 goes first
    cfgw(CFG_ADVANCED_IRQ_MODE_TOP, 8'h05);
    cfgw(CFG_ADVANCED_IRQ_MODE_TOP, 8'h18);
    cfgr(CFG_ADVANCED_IRQ_MODE_TOP, 8'h05);
    isa = 16'h0050;
    wmsg(5'd6);
    isa = 16'h0000;
    cyc(2);
    adv = 1'b0;
  endtask : t_advanced_irq_mode
  task t_smi;
    logic seen;
    seen = 1'b0;
    activity = 4'h0;
    pm_en = 1'b1;
    repeat (30) begin
      cyc(1);
      if (smi_n === 1'b0) seen = 1'b1;
    end
    chk(seen, 1'b1);
    pm_en = 1'b0;
    activity = 4'hf;
    cyc(12);
    chk(smi_n, 1'b1);
  endtask : t_smi
  ////////////////////////////////////////////////////////////////
  // clock, watchdog, main sequence
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #200000;
    failures++;
    finish_test();
  end
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    {io_wr, io_rd, cfg_wr, cfg_rd, adv, inta_req, refresh, pm_en, t2_out} = 9'h000;
    {io_addr, io_wdata, cfg_addr, cfg_wdata} = 32'h0;
    {perr_n, serr_n, chk_n, ierr_a, ierr_b} = 5'h1c;
    slot_n = 20'hfffff;
    onb_n = 4'hf;
    isa = 16'h0000;
    activity = 4'hf;
    cyc(5);
    srst = 1'b0;
    t_reset();
    t_status();
    t_freeze();
    t_nmi();
    t_chk();
    t_route();
    t_legacy();
    t_advanced_irq_mode();
    t_smi();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
